// file: tacs_sequencer.sv
// Conversion sequencer: control registers, mode decode, single/slave/master
// sequencing, repeat timer, result steering and limit alerts.
// Assumes an outside ADC core answering convStart with a convDone pulse.
//
// Contract
// - control one: diff, input, readback, mode fields
// - both control registers clear at reset
// - mode 00 none, 01 single, 10 slave, 11 master
// - single mode converts the selected input once
// - no repeat: mode clears to 00, idle
// - repeat set: mode kept, rerun on timer
// - slave sequence converts enabled inputs, stores results
// - master mode waits for touch, then sequences
// - next master run on new touch or timer
// - compare aux_in_one, batteries, diode_temp_one against limits
// - out of limit sets status, drives alarm
// - limit registers at addresses 04 through 0B
// - battery inputs 6 and 7, results 16h/17h
// - aux inputs 3 to 5, results 13h-15h
// - battery divider on only while sampling battery
// - temperature compare uses raw diode result
// - repeat interval once, 1024, 2048, 16384 clocks
// - master timer only while touched, release stops
// - temp inputs 8 and 9, results 18h/19h
`timescale 1ns/1ps
module tacs_sequencer
   import tacs_pkg::*;
#(
   parameter int REP_LONG_CLK = 16384
) (
   input  wire logic                           mclk,         // Conversion clock
   input  wire logic                           srst,         // Sync reset, high
   input  wire logic                           ce,           // Clock enable
   input  wire logic                           regWrite,     // Register write strobe
   input  wire logic [tacs_pkg::ADDR_W-1:0]    regAddr,      // Register write address
   input  wire logic [tacs_pkg::DATA_W-1:0]    regWdata,     // Register write data
   input  wire logic                           penDown,      // Screen touched level
   input  wire logic                           convDone,     // ADC result valid pulse
   input  wire logic [tacs_pkg::DATA_W-1:0]    convResult,   // ADC result
   output logic                                convStart,    // Start conversion pulse
   output tacs_pkg::tacs_conv_type             convReq,      // Channel and diff select
   output logic [1:0]                          batDivEnable, // Battery dividers on
   output logic                                alertOut,     // Alarm pin
   output logic [tacs_pkg::DATA_W-1:0]         readData      // Readback register
);
   import tacs_pkg::*;

   // Timer wide enough for the longest interval, also when the long one is shortened
   localparam int TW = $clog2((REP_LONG_CLK > REP_MID_CLK) ? REP_LONG_CLK : REP_MID_CLK);

   logic [DATA_W-1:0] cr1;
   logic [DATA_W-1:0] cr2;
   logic [DATA_W-1:0] seqSlave;
   logic [DATA_W-1:0] seqMaster;
   logic [DATA_W-1:0] limHi [NUM_LIMITS];
   logic [DATA_W-1:0] limLo [NUM_LIMITS];
   logic [3:0]        alertStatus;
   logic [3:0]        alertEnable;
   logic [NUM_LIMITS-1:0] alertSet;
   tacs_state_type    state;
   logic [NUM_CH-1:0] pending;
   logic [3:0]        curChan;
   logic [TW-1:0]     timer;
   logic [DATA_W-1:0] memRdata;
   logic [DATA_W-1:0] next_readData;

   logic [1:0] mode;
   logic [1:0] repSel;
   logic [4:0] rdAddr;
   logic       hostCr1;
   logic       seqEnd;
   logic       clearMode;
   logic       resultWrite;
   logic [TW-1:0] repeatLoad;

   function automatic logic [3:0] lowestSet(input logic [NUM_CH-1:0] mask);
      logic [3:0] idx;
      idx = 4'h0;
      for (int k = NUM_CH - 1; k >= 0; k--) begin
         if (mask[k]) begin
            idx = 4'(k);
         end
      end
      return idx;
   endfunction

   function automatic logic [NUM_CH-1:0] singleMask(input logic [3:0] chan);
      logic [NUM_CH-1:0] m;
      m = '0;
      if (int'(chan) < NUM_CH) begin
         m[chan] = 1'b1;
      end
      return m;
   endfunction

   function automatic logic [NUM_CH-1:0] reloadMask(input logic [1:0] md,
                                                    input logic [DATA_W-1:0] c1,
                                                    input logic [DATA_W-1:0] sSl,
                                                    input logic [DATA_W-1:0] sMa);
      logic [NUM_CH-1:0] m;
      m = '0;
      case (md)
         MODE_SINGLE: m = singleMask(c1[CR1_IN_HI:CR1_IN_LO]);
         MODE_SLAVE:  m = sSl[NUM_CH-1:0];
         MODE_MASTER: m = sMa[NUM_CH-1:0];
         default:     m = '0;
      endcase
      return m;
   endfunction

   assign mode    = cr1[CR1_MODE_HI:CR1_MODE_LO];
   assign repSel  = cr2[CR2_REP_HI:CR2_REP_LO];
   assign rdAddr  = cr1[CR1_RD_HI:CR1_RD_LO];
   assign hostCr1 = regWrite && (regAddr == CR1_ADDR);
   assign seqEnd  = (state == ST_ISSUE) && (pending == '0);
   assign clearMode = seqEnd && (mode != MODE_MASTER) && (repSel == REP_ONCE);
   assign resultWrite = (state == ST_CONVERT) && convDone && !hostCr1;

   always_comb begin
      case (repSel)
         REP_SHORT: repeatLoad = TW'(REP_SHORT_CLK - 1);
         REP_MID:   repeatLoad = TW'(REP_MID_CLK - 1);
         REP_LONG:  repeatLoad = TW'(REP_LONG_CLK - 1);
         default:   repeatLoad = '0;
      endcase
   end

   // Control register one; a host write wins over the hardware mode clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         cr1 <= REG_RESET;
      end else if (ce) begin
         if (hostCr1) begin
            cr1 <= regWdata;
         end else if (clearMode) begin
            cr1[CR1_MODE_HI:CR1_MODE_LO] <= MODE_NONE;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cr2       <= REG_RESET;
         seqSlave  <= REG_RESET;
         seqMaster <= REG_RESET;
      end else if (ce && regWrite) begin
         if (regAddr == CR2_ADDR) begin
            cr2 <= regWdata;
         end
         if (regAddr == SEQ_SLAVE_ADDR) begin
            seqSlave <= regWdata;
         end
         if (regAddr == SEQ_MASTER_ADDR) begin
            seqMaster <= regWdata;
         end
      end
   end

   // Limit pairs: high at even, low at odd address from the first limit
   for (genvar i = 0; i < NUM_LIMITS; i++) begin : g_limit
      localparam logic [4:0] HI_ADDR = 5'(LIMIT_FIRST + 2 * i);
      localparam logic [4:0] LO_ADDR = 5'(LIMIT_FIRST + 2 * i + 1);

      always_ff @(posedge mclk) begin
         if (srst) begin
            limHi[i] <= REG_RESET;
            limLo[i] <= REG_RESET;
         end else if (ce && regWrite) begin
            if (regAddr == HI_ADDR) begin
               limHi[i] <= regWdata;
            end
            if (regAddr == LO_ADDR) begin
               limLo[i] <= regWdata;
            end
         end
      end

      // Raw result compare, no unit conversion
      assign alertSet[i] = resultWrite && (curChan == CMP_CH_LIST[4*i +: 4]) &&
                           ((convResult > limHi[i]) ||
                            (convResult < limLo[i]));
   end

   // Sticky status, write one to clear, new event wins over the clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         alertStatus <= 4'h0;
         alertEnable <= 4'h0;
      end else if (ce) begin
         if (regWrite && (regAddr == ALERT_ADDR)) begin
            alertEnable <= regWdata[ALERT_EN_LO +: 4];
            alertStatus <= (alertStatus & ~regWdata[ALERT_ST_LO +: 4]) | alertSet;
         end else begin
            alertStatus <= alertStatus | alertSet;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         alertOut <= 1'b0;
      end else if (ce) begin
         alertOut <= |(alertStatus & alertEnable);
      end
   end

   // Sequencer; a control one write restarts it in the new mode
   always_ff @(posedge mclk) begin
      if (srst) begin
         state   <= ST_IDLE;
         pending <= '0;
         curChan <= 4'h0;
         timer   <= '0;
      end else if (ce) begin
         if (hostCr1) begin
            case (regWdata[CR1_MODE_HI:CR1_MODE_LO])
               MODE_SINGLE, MODE_SLAVE: begin
                  pending <= reloadMask(regWdata[CR1_MODE_HI:CR1_MODE_LO], regWdata,
                                        seqSlave, seqMaster);
                  state   <= ST_ISSUE;
               end
               MODE_MASTER: begin
                  pending <= '0;
                  state   <= ST_WAIT_TOUCH;
               end
               default: begin
                  pending <= '0;
                  state   <= ST_IDLE;
               end
            endcase
         end else begin
            case (state)
               ST_IDLE: begin
                  pending <= '0;
               end
               ST_WAIT_TOUCH: begin
                  if (penDown) begin
                     pending <= seqMaster[NUM_CH-1:0];
                     state   <= ST_ISSUE;
                  end
               end
               ST_WAIT_RELEASE: begin
                  if (!penDown) begin
                     state <= ST_WAIT_TOUCH;
                  end
               end
               ST_ISSUE: begin
                  if (pending != '0) begin
                     curChan <= lowestSet(pending);
                     state   <= ST_CONVERT;
                  end else if (mode == MODE_MASTER) begin
                     if (penDown && (repSel != REP_ONCE)) begin
                        timer <= repeatLoad;
                        state <= ST_REPEAT;
                     end else if (penDown) begin
                        state <= ST_WAIT_RELEASE;
                     end else begin
                        state <= ST_WAIT_TOUCH;
                     end
                  end else if (repSel == REP_ONCE) begin
                     state <= ST_IDLE;
                  end else begin
                     timer <= repeatLoad;
                     state <= ST_REPEAT;
                  end
               end
               ST_CONVERT: begin
                  if (convDone) begin
                     pending[curChan] <= 1'b0;
                     state            <= ST_ISSUE;
                  end
               end
               ST_REPEAT: begin
                  if ((mode == MODE_MASTER) && !penDown) begin
                     state <= ST_WAIT_TOUCH;
                  end else if (timer == '0) begin
                     pending <= reloadMask(mode, cr1, seqSlave, seqMaster);
                     state   <= ST_ISSUE;
                  end else begin
                     timer <= timer - 1'b1;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Conversion request and battery divider control
   always_ff @(posedge mclk) begin
      if (srst) begin
         convStart    <= 1'b0;
         convReq      <= '0;
         batDivEnable <= 2'h0;
      end else if (ce) begin
         convStart <= seqEnd ? 1'b0 : ((state == ST_ISSUE) && !hostCr1);
         if ((state == ST_ISSUE) && !seqEnd && !hostCr1) begin
            convReq.channel <= lowestSet(pending);
            convReq.diff    <= cr1[CR1_DIFF_BIT];
            batDivEnable[0] <= (lowestSet(pending) == CH_BATTERY_IN_ONE);
            batDivEnable[1] <= (lowestSet(pending) == CH_BATTERY_IN_TWO);
         end else if (convDone || hostCr1 || (state != ST_CONVERT)) begin
            batDivEnable <= 2'h0;
         end
      end
   end

   // Result at readback address 10000b plus input code
   tacs_result_mem #(
      .WIDTH  (DATA_W),
      .DEPTH  (16),
      .AWIDTH (4)
   ) u_results (
      .mclk   (mclk),
      .ce     (ce),
      .wrEn   (resultWrite),
      .wrAddr (curChan),
      .wrData (convResult),
      .rdAddr (rdAddr[3:0]),
      .rdData (memRdata)
   );

   always_comb begin
      next_readData = '0;
      if (rdAddr[RESULT_SEL_BIT]) begin
         next_readData = memRdata;
      end else if (rdAddr == CR1_ADDR) begin
         next_readData = cr1;
      end else if (rdAddr == CR2_ADDR) begin
         next_readData = cr2;
      end else if (rdAddr == ALERT_ADDR) begin
         next_readData = DATA_W'({alertEnable, alertStatus});
      end else if (rdAddr == SEQ_SLAVE_ADDR) begin
         next_readData = seqSlave;
      end else if (rdAddr == SEQ_MASTER_ADDR) begin
         next_readData = seqMaster;
      end else if ((rdAddr >= LIMIT_FIRST) && (rdAddr <= LIMIT_LAST)) begin
         for (int j = 0; j < NUM_LIMITS; j++) begin
            if (rdAddr == 5'(LIMIT_FIRST + 2 * j)) begin
               next_readData = limHi[j];
            end
            if (rdAddr == 5'(LIMIT_FIRST + 2 * j + 1)) begin
               next_readData = limLo[j];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         readData <= '0;
      end else if (ce) begin
         readData <= next_readData;
      end
   end

   a_ctrl_reset: assert property (@(posedge mclk) srst |=> (cr1 == REG_RESET) && (cr2 == REG_RESET))
      else $error("control registers not cleared by reset");

   a_start_pulse: assert property (@(posedge mclk) disable iff (srst)
      convStart |=> !convStart)
      else $error("conversion start longer than one cycle");

   a_mode_revert: assert property (@(posedge mclk) disable iff (srst)
      (ce && seqEnd && !hostCr1 && (mode != MODE_MASTER) && (repSel == REP_ONCE))
      |=> (cr1[CR1_MODE_HI:CR1_MODE_LO] == MODE_NONE) && (state == ST_IDLE))
      else $error("mode did not revert to none after one run");

   a_mode_keep: assert property (@(posedge mclk) disable iff (srst)
      (ce && seqEnd && !hostCr1 && (repSel != REP_ONCE) && (mode != MODE_MASTER))
      |=> $stable(cr1) && (state == ST_REPEAT) && (timer == repeatLoad))
      else $error("repeat run did not keep mode and load timer");

   a_touch_wait: assert property (@(posedge mclk) disable iff (srst)
      (ce && (state == ST_WAIT_TOUCH) && !penDown && !hostCr1) |=> ##1 !convStart)
      else $error("master mode converted without a touch");

   a_release_stop: assert property (@(posedge mclk) disable iff (srst)
      (ce && (state == ST_REPEAT) && (mode == MODE_MASTER) && !penDown && !hostCr1)
      |=> (state == ST_WAIT_TOUCH))
      else $error("release did not stop the repeat timer");

   a_bat_divider: assert property (@(posedge mclk) disable iff (srst)
      (batDivEnable != 2'h0) |-> (state == ST_CONVERT) &&
      (convReq.channel == (batDivEnable[0] ? CH_BATTERY_IN_ONE : CH_BATTERY_IN_TWO)))
      else $error("battery divider on outside a battery sample");

   a_alert_sticky: assert property (@(posedge mclk) disable iff (srst)
      (ce && (alertSet != 4'h0)) |=> ((alertStatus & $past(alertSet)) == $past(alertSet)))
      else $error("out of limit result did not set status");

   a_alarm_pin: assert property (@(posedge mclk) disable iff (srst)
      ce |=> (alertOut == $past(|(alertStatus & alertEnable))))
      else $error("alarm pin does not follow enabled status");
endmodule // tacs_sequencer

// file: tacs_pkg.sv
// Constants, types and register map of the touch ADC conversion sequencer.
// Assumes a 10 MHz conversion clock and a 5-bit register address space.
package tacs_pkg;
   localparam int DATA_W = 12;
   localparam int ADDR_W = 5;
   localparam int NUM_CH = 11;
   localparam int NUM_LIMITS = 4;

   // Register addresses
   localparam logic [4:0] CR1_ADDR        = 5'h01;
   localparam logic [4:0] CR2_ADDR        = 5'h02;
   localparam logic [4:0] ALERT_ADDR      = 5'h03;
   localparam logic [4:0] LIMIT_FIRST     = 5'h04;
   localparam logic [4:0] LIMIT_LAST      = 5'h0B;
   localparam logic [4:0] SEQ_SLAVE_ADDR  = 5'h0C;
   localparam logic [4:0] SEQ_MASTER_ADDR = 5'h0D;
   localparam int         RESULT_SEL_BIT  = 4;

   localparam logic [11:0] REG_RESET = 12'h000;

   // Control register one and two fields
   localparam int CR1_DIFF_BIT = 11;
   localparam int CR1_IN_HI    = 10;
   localparam int CR1_IN_LO    = 7;
   localparam int CR1_RD_HI    = 6;
   localparam int CR1_RD_LO    = 2;
   localparam int CR1_MODE_HI  = 1;
   localparam int CR1_MODE_LO  = 0;
   localparam int CR2_REP_HI   = 1;
   localparam int CR2_REP_LO   = 0;

   // Alert status/enable layout
   localparam int ALERT_ST_LO = 0;
   localparam int ALERT_EN_LO = 4;

   localparam logic [1:0] MODE_NONE   = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_SLAVE  = 2'h2;
   localparam logic [1:0] MODE_MASTER = 2'h3;

   localparam logic [1:0] REP_ONCE  = 2'h0;
   localparam logic [1:0] REP_SHORT = 2'h1;
   localparam logic [1:0] REP_MID   = 2'h2;
   localparam logic [1:0] REP_LONG  = 2'h3;
   localparam int REP_SHORT_CLK = 1024;
   localparam int REP_MID_CLK   = 2048;

   localparam logic [3:0] CH_AUX_IN_ONE  = 4'h3;
   localparam logic [3:0] CH_AUX_IN_TWO  = 4'h4;
   localparam logic [3:0] CH_AUX_IN_THREE  = 4'h5;
   localparam logic [3:0] CH_BATTERY_IN_ONE  = 4'h6;
   localparam logic [3:0] CH_BATTERY_IN_TWO  = 4'h7;
   localparam logic [3:0] CH_DIODE_TEMP_ONE = 4'h8;
   localparam logic [3:0] CH_DIODE_TEMP_TWO = 4'h9;

   // Compared inputs, limit pair index 0..3
   localparam logic [15:0] CMP_CH_LIST = {CH_DIODE_TEMP_ONE, CH_BATTERY_IN_TWO, CH_BATTERY_IN_ONE, CH_AUX_IN_ONE};

   typedef struct packed {
      logic       diff;
      logic [3:0] channel;
   } tacs_conv_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_TOUCH, ST_WAIT_RELEASE, ST_ISSUE, ST_CONVERT, ST_REPEAT
   } tacs_state_type;
endpackage

// file: tacs_result_mem.sv
// Result register file: one word per input channel, registered read.
// Assumes one write port driven by the sequencer, read address from readback.
`timescale 1ns/1ps
module tacs_result_mem #(
   parameter int WIDTH  = 12,
   parameter int DEPTH  = 16,
   parameter int AWIDTH = 4
) (
   input  wire logic              mclk,   // Conversion clock
   input  wire logic              ce,     // Clock enable
   input  wire logic              wrEn,   // Write strobe
   input  wire logic [AWIDTH-1:0] wrAddr, // Write index
   input  wire logic [WIDTH-1:0]  wrData, // Write data
   input  wire logic [AWIDTH-1:0] rdAddr, // Read index
   output logic      [WIDTH-1:0]  rdData  // Registered read data
);
   logic [WIDTH-1:0] store [DEPTH];

   always_ff @(posedge mclk) begin
      if (ce && wrEn) begin
         store[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (ce) begin
         rdData <= store[rdAddr];
      end
   end
endmodule // tacs_result_mem

// file: tacs_adc_model.sv
// ADC core model: answers each start pulse with one result pulse.
// Assumes the bench sets delay and value before the answer falls due.
`timescale 1ns/1ps
module tacs_adc_model
   import tacs_pkg::*;
(
   input  wire logic                        mclk,      // Conversion clock
   input  wire logic                        convStart, // Start pulse
   input  wire logic [3:0]                  lat,       // Answer delay
   input  wire logic [tacs_pkg::DATA_W-1:0] resVal,    // Answer value
   output logic                             convDone,  // Result pulse
   output logic      [tacs_pkg::DATA_W-1:0] convResult // Result, valid with pulse
);
   int                cnt = 0;
   logic [DATA_W-1:0] last = '0;
   initial convDone = 1'b0;
   initial convResult = '1;
   // Outside the pulse the data shows the inverse of the last answer
   always @(posedge mclk) begin
      convDone <= 1'b0;
      convResult <= ~last;
      if (convStart === 1'b1) begin
         cnt <= lat + 1;
      end else if (cnt == 1) begin
         convDone <= 1'b1;
         convResult <= resVal;
         last <= resVal;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule // tacs_adc_model

// file: tacs_sequencer_tb_top.sv
// Bench of the conversion sequencer: host writes, queue model of starts, result checks.
// Assumes tacs_pkg and the ADC core model.
`timescale 1ns/1ps
module tacs_sequencer_tb_top;
   import tacs_pkg::*;
   localparam int LONG = 40;
   logic mclk = 0, srst = 1, ce = 1, regWrite = 0, penDown = 0;
   logic convDone, convStart, alertOut;
   logic [4:0] regAddr = '0;
   logic [11:0] regWdata = '0, resVal = '0, hot = '0, convResult, readData;
   logic [3:0] lat = 4'h2;
   logic [1:0] batDivEnable;
   tacs_conv_type convReq;
   int err_count = 0, checked = 0, cyc = 0, seed = 10, doneCyc = 0, gap = 0, iv = 0;
   logic [4:0] expQ[$];
   logic [11:0] res[16];
   always #50 mclk = ~mclk;
   tacs_sequencer #(.REP_LONG_CLK(LONG)) u_dut (.mclk, .srst, .ce, .regWrite, .regAddr,
      .regWdata, .penDown, .convDone, .convResult, .convStart, .convReq, .batDivEnable,
      .alertOut, .readData);
   tacs_adc_model u_adc (.mclk, .convStart, .lat, .resVal, .convDone, .convResult);
   task automatic close_out;
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [11:0] d);
      @(negedge mclk);
      regWrite = 1'b1;
      regAddr = a;
      regWdata = d;
      @(negedge mclk);
      regWrite = 1'b0;
   endtask
   task automatic wq(input int lim);
      for (int i = 0; i < lim && expQ.size() != 0; i++) @(negedge mclk);
      if (expQ.size() != 0) chk(12'(expQ.size()), 12'h000);
      repeat (12) @(negedge mclk);
   endtask
   task automatic run(input logic [11:0] c, input int lim);
      wr(CR1_ADDR, c);
      wq(lim);
   endtask
   // Every start is matched against the oldest expected request
   always @(negedge mclk) begin
      cyc++;
      if (cyc > 20000) begin
         err_count++;
         close_out();
      end
      if (convDone === 1'b1) doneCyc = cyc;
      if (convStart === 1'b1) begin
         gap = cyc - doneCyc;
         lat = 4'($random(seed) & 7);
         resVal = (hot != 0) ? hot : 12'h200 + 12'($random(seed) & 12'h7FF);
         if (expQ.size() == 0) chk(12'hEEE, 12'h000);
         else begin
            chk(12'(convReq), 12'(expQ[0]));
            chk(12'(batDivEnable), {10'h0, expQ[0][3:0] == CH_BATTERY_IN_TWO,
                expQ[0][3:0] == CH_BATTERY_IN_ONE});
            res[expQ[0][3:0]] = resVal;
            void'(expQ.pop_front());
         end
      end
   end
   initial begin
      repeat (6) @(negedge mclk);
      srst = 1'b0;
      chk(readData, 12'h000);
      wr(CR1_ADDR, 12'h008);
      repeat (3) @(negedge mclk);
      chk(readData, 12'h000);
      wr(CR1_ADDR, 12'h004);
      repeat (3) @(negedge mclk);
      chk(readData, 12'h004);
      for (int i = 0; i < 4; i++) begin
         wr(LIMIT_FIRST + 5'(2 * i), 12'hC00);
         wr(LIMIT_FIRST + 5'(2 * i + 1), 12'h100);
      end
      wr(ALERT_ADDR, 12'h0F0);
      for (int c = 3; c < 11; c++) begin
         expQ.push_back({c[0], 4'(c)});
         run({c[0], 4'(c), 5'h10 + 5'(c), MODE_SINGLE}, 100);
         chk(readData, res[c]);
      end
      chk(12'(alertOut), 12'h000);
      expQ.push_back(5'h08);
      run(12'h405, 100);
      chk(readData, 12'h404);
      hot = 12'h050;
      expQ.push_back(5'h06);
      run({1'b0, 4'h6, 5'h03, MODE_SINGLE}, 100);
      chk(readData, 12'h0F2);
      hot = 12'hFFF;
      expQ.push_back(5'h08);
      run({1'b0, 4'h8, 5'h03, MODE_SINGLE}, 100);
      chk(readData, 12'h0FA);
      chk(12'(alertOut), 12'h001);
      hot = 12'h000;
      wr(ALERT_ADDR, 12'h0FA);
      repeat (3) @(negedge mclk);
      chk(readData, 12'h0F0);
      chk(12'(alertOut), 12'h000);
      ce = 1'b0;
      wr(CR1_ADDR, 12'h030);
      repeat (2 + ($random(seed) & 3)) @(negedge mclk);
      chk(readData, 12'h0F0);
      ce = 1'b1;
      repeat (3) @(negedge mclk);
      chk(readData, 12'h0F0);
      wr(SEQ_SLAVE_ADDR, 12'h3C8);
      expQ = {5'h13, 5'h16, 5'h17, 5'h18, 5'h19};
      run({1'b1, 4'h0, 5'h19, MODE_SLAVE}, 300);
      chk(readData, res[9]);
      for (int r = 1; r < 4; r++) begin
         iv = (r == 1) ? REP_SHORT_CLK : (r == 2) ? REP_MID_CLK : LONG;
         wr(CR2_ADDR, 12'(r));
         expQ = {5'h05, 5'h05};
         run({1'b0, 4'h5, 5'h15, MODE_SINGLE}, 3000);
         wr(CR1_ADDR, 12'h000);
         chk(12'(gap >= iv && gap <= iv + 4), 12'h001);
      end
      wr(CR2_ADDR, 12'h000);
      wr(SEQ_MASTER_ADDR, 12'h008);
      wr(CR1_ADDR, {1'b0, 4'h0, 5'h13, MODE_MASTER});
      repeat (30) @(negedge mclk);
      expQ.push_back(5'h03);
      penDown = 1'b1;
      wq(50);
      repeat (40) @(negedge mclk);
      penDown = 1'b0;
      repeat (5) @(negedge mclk);
      expQ.push_back(5'h03);
      penDown = 1'b1;
      wq(50);
      chk(readData, res[3]);
      wr(CR1_ADDR, 12'h000);
      penDown = 1'b0;
      wr(CR2_ADDR, 12'h003);
      wr(CR1_ADDR, {1'b0, 4'h0, 5'h13, MODE_MASTER});
      expQ = {5'h03, 5'h03};
      penDown = 1'b1;
      wq(200);
      penDown = 1'b0;
      repeat (100) @(negedge mclk);
      expQ.push_back(5'h03);
      penDown = 1'b1;
      wq(20);
      wr(CR1_ADDR, 12'h000);
      close_out();
   end
endmodule // tacs_sequencer_tb_top
